// >>> core/oarg_pkg.sv
package oarg_pkg;

    localparam int KEY_W = 256;
    localparam int ICV_W = 64;
    localparam int WORD_W = 32;
    localparam int AUTH_WORDS = 8;
    localparam int NUM_ACCT = 4;
    localparam int ACCT_W = 2;
    localparam int LIMIT_W = 8;
    localparam int FAIL_W = 8;
    localparam int THR_W = 10;
    localparam int DLY_W = 16;

    // Integrity check vector that a correct key unwrap recovers.
    localparam logic [ICV_W-1:0] ICV_EXPECTED = 64'ha6a6a6a6a6a6a6a6;

    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
    localparam logic [7:0] ADDR_THRESH = 8'h10;
    localparam logic [7:0] ADDR_ACCT_BASE = 8'h20;
    localparam logic [7:0] ADDR_AUTH_BASE = 8'h40;

    localparam int CTRL_START = 0;
    localparam int CTRL_LOGOUT = 1;
    localparam int CTRL_ACCT_LSB = 4;

    localparam int STAT_BUSY = 0;
    localparam int STAT_ROLE_LSB = 1;
    localparam int STAT_DP_LSB = 4;
    localparam int STAT_FAIL = 7;
    localparam int STAT_THROT = 8;
    localparam int STAT_LOCK = 9;
    localparam int STAT_CNT_LSB = 16;

    localparam int IRQ_OK = 0;
    localparam int IRQ_FAIL = 1;
    localparam int IRQ_LOCK = 2;
    localparam int IRQ_W = 3;

    localparam int CFG_DUAL = 0;
    localparam int CFG_LIMIT_LSB = 8;

    localparam int DP_SECURE = 0;
    localparam int DP_MIGRATE = 1;
    localparam int DP_PREBOOT = 2;
    localparam int DP_W = 3;

    localparam int HTRANS_ACTIVE = 1;
    localparam logic HRESP_OKAY = 1'b0;

    localparam logic [THR_W-1:0] THR_MAX = 10'h280;
    localparam logic [THR_W-1:0] THR_RESET = THR_MAX;
    localparam logic [LIMIT_W-1:0] LIMIT_RESET = 8'h0a;
    localparam logic [FAIL_W-1:0] FAIL_MAX = 8'hff;

    localparam logic [ACCT_W-1:0] ACCT_INITIATOR = 2'h0;
    localparam logic [ACCT_W-1:0] ACCT_OFFICER = 2'h1;
    localparam logic [ACCT_W-1:0] ACCT_MANAGER = 2'h2;
    localparam logic [ACCT_W-1:0] ACCT_LIMITED = 2'h3;

    typedef enum logic [2:0] {
        OARG_SH_NONE,
        OARG_SH_INITIATOR,
        OARG_SH_OFFICER,
        OARG_SH_MANAGER,
        OARG_SH_LIMITED
    } oarg_sh_role_t;

    function automatic oarg_sh_role_t acct_role(input logic [ACCT_W-1:0] a);
        unique case (a)
            ACCT_INITIATOR: acct_role = OARG_SH_INITIATOR;
            ACCT_OFFICER: acct_role = OARG_SH_OFFICER;
            ACCT_MANAGER: acct_role = OARG_SH_MANAGER;
            ACCT_LIMITED: acct_role = OARG_SH_LIMITED;
        endcase
    endfunction

    function automatic logic [DP_W-1:0] acct_dp(input logic [ACCT_W-1:0] a);
        acct_dp = '0;
        if (a != ACCT_INITIATOR) begin
            acct_dp[DP_SECURE] = 1'b1;
        end
        if (a == ACCT_OFFICER) begin
            acct_dp[DP_MIGRATE] = 1'b1;
            acct_dp[DP_PREBOOT] = 1'b1;
        end
    endfunction

    function automatic logic is_acct(input logic [7:0] a);
        is_acct = (a[7:4] == ADDR_ACCT_BASE[7:4]);
    endfunction

    function automatic logic is_auth(input logic [7:0] a);
        is_auth = (a[7:5] == ADDR_AUTH_BASE[7:5]);
    endfunction

endpackage

// >>> core/oarg_fail_track.sv
module oarg_fail_track import oarg_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [ACCT_W-1:0] acct,
    input wire logic fail_evt,
    input wire logic ok_evt,
    input wire logic [NUM_ACCT*LIMIT_W-1:0] limits,
    output logic [FAIL_W-1:0] cnt,
    output logic locked,
    output logic lockout_evt
);
    logic [FAIL_W-1:0] cnt_reg [NUM_ACCT];
    logic [LIMIT_W-1:0] lim;

    assign lim = limits[acct*LIMIT_W +: LIMIT_W];
    assign cnt = cnt_reg[acct];
    // A limit of zero means the account never locks.
    assign locked = (lim != '0) && (cnt >= FAIL_W'(lim));
    assign lockout_evt = fail_evt && (lim != '0) && (cnt == FAIL_W'(lim - 1'b1));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NUM_ACCT; i++) begin
                cnt_reg[i] <= '0;
            end
        end else if (fail_evt && cnt != FAIL_MAX) begin
            cnt_reg[acct] <= cnt + 1'b1;
        end else if (ok_evt) begin
            cnt_reg[acct] <= '0;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_FAIL_COUNT: assert property (fail_evt && cnt != FAIL_MAX |=> cnt_reg[$past(acct)] == $past(cnt) + 1'b1)
        else $error("Failed login did not advance the account count.");
    AST_LOCK_LIMIT: assert property (lockout_evt ##1 (acct == $past(acct) && $stable(limits)) |-> locked)
        else $error("Account that reached its limit is not locked.");
endmodule

// >>> core/oarg_blocker.sv
module oarg_blocker import oarg_pkg::*; #(
    parameter logic [DLY_W-1:0] DELAY_CYC = 16'h0fa0
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic req,
    input wire logic fail_evt,
    input wire logic ok_evt,
    input wire logic [THR_W-1:0] threshold,
    output logic grant,
    output logic throttled
);
    logic [THR_W-1:0] fail_tot_reg;
    logic [DLY_W-1:0] wait_reg;

    assign throttled = (fail_tot_reg >= threshold);
    assign grant = req && (!throttled || wait_reg >= DELAY_CYC - 1'b1);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fail_tot_reg <= '0;
        end else if (fail_evt && fail_tot_reg != '1) begin
            fail_tot_reg <= fail_tot_reg + 1'b1;
        end else if (ok_evt) begin
            fail_tot_reg <= '0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_reg <= '0;
        end else if (!req || grant) begin
            wait_reg <= '0;
        end else begin
            wait_reg <= wait_reg + 1'b1;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_THROTTLE_WAIT: assert property (grant && throttled |-> wait_reg == DELAY_CYC - 1'b1)
        else $error("Throttled request granted before its delay ran out.");
    COV_THROTTLED_GRANT: cover property (grant && throttled);
endmodule

// >>> core/oarg_gate.sv
module oarg_gate import oarg_pkg::*; #(
    parameter logic [DLY_W-1:0] BLOCK_DELAY_CYC = 16'h0fa0
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [WORD_W-1:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [WORD_W-1:0] hrdata,
    input wire logic [KEY_W-1:0] key_port_value,
    output logic uw_start,
    output logic uw_stage,
    output logic [KEY_W-1:0] uw_key,
    input wire logic uw_done,
    input wire logic [ICV_W-1:0] uw_icv,
    input wire logic [KEY_W-1:0] uw_key_out,
    output oarg_sh_role_t sh_role,
    output logic [DP_W-1:0] dp_rights,
    output logic irq
);
    // Only the authenticated path exists; there is no way around the unwraps.
    typedef enum logic [2:0] {
        OARG_ST_IDLE,
        OARG_ST_THROTTLE,
        OARG_ST_UW1_REQ,
        OARG_ST_UW1_WAIT,
        OARG_ST_UW2_REQ,
        OARG_ST_UW2_WAIT
    } oarg_state_t;

    oarg_state_t state_reg;
    oarg_state_t state_next;
    logic dp_wr_reg;
    logic [7:0] dp_addr_reg;
    logic [WORD_W-1:0] rdata_reg;
    logic [WORD_W-1:0] rdata_next;
    logic [WORD_W-1:0] auth_word_reg [AUTH_WORDS];
    logic [KEY_W-1:0] auth_val;
    logic [KEY_W-1:0] val_key;
    logic [NUM_ACCT*LIMIT_W-1:0] limit_reg;
    logic [NUM_ACCT-1:0] dual_reg;
    logic [THR_W-1:0] thresh_reg;
    logic [IRQ_W-1:0] irq_stat_reg;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic [IRQ_W-1:0] irq_evt;
    logic [ACCT_W-1:0] cur_acct_reg;
    logic [KEY_W-1:0] uw_key_reg;
    logic uw_stage_reg;
    oarg_sh_role_t sh_role_reg;
    logic [DP_W-1:0] dp_reg;
    logic last_fail_reg;
    logic ap_valid;
    logic wr_ctrl;
    logic start_pulse;
    logic logout_pulse;
    logic officer_wr;
    logic icv_pass;
    logic login_ok_evt;
    logic login_fail_evt;
    logic acct_locked;
    logic lockout_evt;
    logic blk_grant;
    logic blk_throttled;
    logic [FAIL_W-1:0] fail_cnt;
    logic logged_in;
    logic [THR_W-1:0] thr_wdata;

    assign ap_valid = hsel && hready && htrans[HTRANS_ACTIVE];
    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;
    assign hrdata = rdata_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_reg <= 1'b0;
            dp_addr_reg <= '0;
        end else if (hready) begin
            dp_wr_reg <= ap_valid && hwrite;
            dp_addr_reg <= haddr[7:0];
        end
    end

    assign logged_in = (sh_role_reg != OARG_SH_NONE);
    assign wr_ctrl = dp_wr_reg && dp_addr_reg == ADDR_CTRL;
    assign start_pulse = wr_ctrl && hwdata[CTRL_START];
    assign logout_pulse = wr_ctrl && hwdata[CTRL_LOGOUT];
    // Account policy may only be changed by a logged-in security officer.
    assign officer_wr = dp_wr_reg && sh_role_reg == OARG_SH_OFFICER;
    assign thr_wdata = hwdata[THR_W-1:0] > THR_MAX ? THR_MAX : hwdata[THR_W-1:0];

    // Reads are prepared in the address phase so the slave never inserts wait states.
    always_comb begin
        rdata_next = '0;
        if (is_acct(haddr[7:0])) begin
            rdata_next[CFG_DUAL] = dual_reg[haddr[3:2]];
            rdata_next[CFG_LIMIT_LSB +: LIMIT_W] = limit_reg[haddr[3:2]*LIMIT_W +: LIMIT_W];
        end else begin
            unique case (haddr[7:0])
                ADDR_CTRL: rdata_next[CTRL_ACCT_LSB +: ACCT_W] = cur_acct_reg;
                ADDR_STATUS: begin
                    rdata_next[STAT_BUSY] = (state_reg != OARG_ST_IDLE);
                    rdata_next[STAT_ROLE_LSB +: 3] = sh_role_reg;
                    rdata_next[STAT_DP_LSB +: DP_W] = dp_reg;
                    rdata_next[STAT_FAIL] = last_fail_reg;
                    rdata_next[STAT_THROT] = blk_throttled;
                    rdata_next[STAT_LOCK] = acct_locked;
                    rdata_next[STAT_CNT_LSB +: FAIL_W] = fail_cnt;
                end
                ADDR_IRQ_STAT: rdata_next[IRQ_W-1:0] = irq_stat_reg;
                ADDR_IRQ_MASK: rdata_next[IRQ_W-1:0] = irq_mask_reg;
                ADDR_THRESH: rdata_next[THR_W-1:0] = thresh_reg;
                default: rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_reg <= '0;
        end else if (ap_valid && !hwrite) begin
            rdata_reg <= rdata_next;
        end
    end

    // Authentication words are write-only; they never read back.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < AUTH_WORDS; i++) begin
                auth_word_reg[i] <= '0;
            end
        end else if (dp_wr_reg && is_auth(dp_addr_reg)) begin
            auth_word_reg[dp_addr_reg[4:2]] <= hwdata;
        end
    end

    always_comb begin
        auth_val = '0;
        for (int i = 0; i < AUTH_WORDS; i++) begin
            auth_val[i*WORD_W +: WORD_W] = auth_word_reg[i];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dual_reg <= '0;
            limit_reg <= {NUM_ACCT{LIMIT_RESET}};
        end else if (officer_wr && is_acct(dp_addr_reg)) begin
            dual_reg[dp_addr_reg[3:2]] <= hwdata[CFG_DUAL];
            limit_reg[dp_addr_reg[3:2]*LIMIT_W +: LIMIT_W] <= hwdata[CFG_LIMIT_LSB +: LIMIT_W];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            thresh_reg <= THR_RESET;
        end else if (officer_wr && dp_addr_reg == ADDR_THRESH) begin
            thresh_reg <= thr_wdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cur_acct_reg <= ACCT_INITIATOR;
        end else if (wr_ctrl && state_reg == OARG_ST_IDLE) begin
            cur_acct_reg <= hwdata[CTRL_ACCT_LSB +: ACCT_W];
        end
    end

    // The account is taken from the same write that starts the login.
    logic [ACCT_W-1:0] start_acct;
    assign start_acct = hwdata[CTRL_ACCT_LSB +: ACCT_W];
    assign val_key = dual_reg[start_acct] ? (auth_val ^ key_port_value) : auth_val;
    assign icv_pass = (uw_icv == ICV_EXPECTED);

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            OARG_ST_IDLE: begin
                if (start_pulse && !acct_locked) begin
                    state_next = OARG_ST_THROTTLE;
                end
            end
            OARG_ST_THROTTLE: begin
                if (blk_grant) begin
                    state_next = OARG_ST_UW1_REQ;
                end
            end
            OARG_ST_UW1_REQ: state_next = OARG_ST_UW1_WAIT;
            OARG_ST_UW1_WAIT: begin
                if (uw_done) begin
                    state_next = icv_pass ? OARG_ST_UW2_REQ : OARG_ST_IDLE;
                end
            end
            OARG_ST_UW2_REQ: state_next = OARG_ST_UW2_WAIT;
            OARG_ST_UW2_WAIT: begin
                if (uw_done) begin
                    state_next = OARG_ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= OARG_ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Lock is judged on the account named in the start write.
    assign login_fail_evt = (state_reg == OARG_ST_IDLE && start_pulse && acct_locked)
        || (state_reg == OARG_ST_UW1_WAIT && uw_done && !icv_pass)
        || (state_reg == OARG_ST_UW2_WAIT && uw_done && !icv_pass);
    assign login_ok_evt = state_reg == OARG_ST_UW2_WAIT && uw_done && icv_pass;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            uw_key_reg <= '0;
            uw_stage_reg <= 1'b0;
        end else if (state_reg == OARG_ST_IDLE && start_pulse) begin
            uw_key_reg <= val_key;
            uw_stage_reg <= 1'b0;
        end else if (state_reg == OARG_ST_UW1_WAIT && uw_done && icv_pass) begin
            uw_key_reg <= uw_key_out;
            uw_stage_reg <= 1'b1;
        end else if (state_reg == OARG_ST_UW2_WAIT && uw_done) begin
            uw_key_reg <= '0;
        end
    end

    assign uw_start = (state_reg == OARG_ST_UW1_REQ) || (state_reg == OARG_ST_UW2_REQ);
    assign uw_stage = uw_stage_reg;
    assign uw_key = uw_key_reg;

    // A completing login wins over a logout written in the same cycle.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sh_role_reg <= OARG_SH_NONE;
            dp_reg <= '0;
        end else if (login_ok_evt) begin
            sh_role_reg <= acct_role(cur_acct_reg);
            dp_reg <= acct_dp(cur_acct_reg);
        end else if (login_fail_evt || logout_pulse) begin
            sh_role_reg <= OARG_SH_NONE;
            dp_reg <= '0;
        end
    end

    assign sh_role = sh_role_reg;
    assign dp_rights = dp_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_fail_reg <= 1'b0;
        end else if (login_fail_evt) begin
            last_fail_reg <= 1'b1;
        end else if (login_ok_evt) begin
            last_fail_reg <= 1'b0;
        end
    end

    oarg_fail_track u_fail_track (
        .hclk(hclk),
        .hresetn(hresetn),
        .acct(state_reg == OARG_ST_IDLE && start_pulse ? start_acct : cur_acct_reg),
        .fail_evt(login_fail_evt),
        .ok_evt(login_ok_evt),
        .limits(limit_reg),
        .cnt(fail_cnt),
        .locked(acct_locked),
        .lockout_evt(lockout_evt)
    );

    oarg_blocker #(
        .DELAY_CYC(BLOCK_DELAY_CYC)
    ) u_blocker (
        .hclk(hclk),
        .hresetn(hresetn),
        .req(state_reg == OARG_ST_THROTTLE),
        .fail_evt(login_fail_evt),
        .ok_evt(login_ok_evt),
        .threshold(thresh_reg),
        .grant(blk_grant),
        .throttled(blk_throttled)
    );

    assign irq_evt[IRQ_OK] = login_ok_evt;
    assign irq_evt[IRQ_FAIL] = login_fail_evt;
    assign irq_evt[IRQ_LOCK] = lockout_evt;

    // Setting has priority over a write-one clear so no event is lost.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_reg <= '0;
        end else if (dp_wr_reg && dp_addr_reg == ADDR_IRQ_STAT) begin
            irq_stat_reg <= (irq_stat_reg & ~hwdata[IRQ_W-1:0]) | irq_evt;
        end else begin
            irq_stat_reg <= irq_stat_reg | irq_evt;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_mask_reg <= '0;
        end else if (dp_wr_reg && dp_addr_reg == ADDR_IRQ_MASK) begin
            irq_mask_reg <= hwdata[IRQ_W-1:0];
        end
    end

    assign irq = |(irq_stat_reg & irq_mask_reg);

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_ROLE_ON_OK: assert property (login_ok_evt |=> sh_role_reg == acct_role($past(cur_acct_reg)))
        else $error("Successful login did not grant the account's role.");
    AST_DP_RIGHTS: assert property (login_ok_evt |=> dp_reg == acct_dp($past(cur_acct_reg)))
        else $error("Datapath rights do not match the account.");
    AST_DUAL_XOR: assert property (state_reg == OARG_ST_IDLE && start_pulse && dual_reg[start_acct]
        |=> uw_key_reg == ($past(auth_val) ^ $past(key_port_value)))
        else $error("Dual-port validation key is not the XOR of both values.");
    AST_SINGLE_KEY: assert property (state_reg == OARG_ST_IDLE && start_pulse && !dual_reg[start_acct]
        |=> uw_key_reg == $past(auth_val))
        else $error("Single-port validation key differs from the request value.");
    AST_ICV_FAIL: assert property (state_reg == OARG_ST_UW1_WAIT && uw_done && !icv_pass
        |=> state_reg == OARG_ST_IDLE && !logged_in)
        else $error("Bad check vector did not abort the login.");
    AST_TWO_PASSES: assert property ($rose(logged_in) |-> $past(login_ok_evt))
        else $error("Role granted without the second unwrap passing.");
    AST_NO_SKIP: assert property (state_reg == OARG_ST_UW2_REQ |-> $past(state_reg) == OARG_ST_UW1_WAIT
        && $past(uw_done) && $past(icv_pass))
        else $error("Second unwrap entered without a passing first unwrap.");
    AST_STAGE2_KEY: assert property (state_reg == OARG_ST_UW1_WAIT && uw_done && icv_pass
        |=> uw_stage_reg && uw_key_reg == $past(uw_key_out) && uw_start)
        else $error("Second unwrap does not use the recovered wrapping key.");
    AST_LOGOUT: assert property (logout_pulse && !login_ok_evt |=> sh_role_reg == OARG_SH_NONE && dp_reg == '0)
        else $error("Logout left a role in place.");
    AST_REJECT: assert property (login_fail_evt |=> sh_role_reg == OARG_SH_NONE && dp_reg == '0
        && irq_stat_reg[IRQ_FAIL])
        else $error("Rejected login left a role or raised no failure flag.");

    COV_LOGIN_OK: cover property (login_ok_evt);
    COV_STAGE2_FAIL: cover property (state_reg == OARG_ST_UW2_WAIT && uw_done && !icv_pass);
    COV_LOCKED_START: cover property (state_reg == OARG_ST_IDLE && start_pulse && acct_locked);
endmodule

// >>> verif/oarg_unwrap_model.sv
module oarg_unwrap_model import oarg_pkg::*; #(
    parameter logic [KEY_W-1:0] VAL_KEY = '0,
    parameter logic [KEY_W-1:0] WRAP_KEY = '1
) (
    input wire logic hclk,
    input wire logic uw_start,
    input wire logic uw_stage,
    input wire logic [KEY_W-1:0] uw_key,
    input wire logic bad2,
    output logic uw_done,
    output logic [ICV_W-1:0] uw_icv,
    output logic [KEY_W-1:0] uw_key_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic ok;
    int lat = 3;
    initial begin
        uw_done = 1'b0;
        uw_icv = '0;
        uw_key_out = '0;
        @(posedge hclk);
        forever begin
            #1;
            if (uw_start === 1'b1) begin
                ok = uw_stage ? (uw_key === WRAP_KEY && !bad2) : (uw_key === VAL_KEY);
                // Prompt and slow answers alternate so no fixed latency is assumed.
                lat = 3 - lat;
                repeat (lat + 1) @(posedge hclk);
                uw_done <= 1'b1;
                uw_icv <= ok ? ICV_EXPECTED : ~ICV_EXPECTED;
                uw_key_out <= ok ? WRAP_KEY : ~uw_key;
                @(posedge hclk);
                uw_done <= 1'b0;
                // Released results are inverted, so a stale passing check vector cannot pass again.
                uw_icv <= ~uw_icv;
                uw_key_out <= ~uw_key_out;
                // No edge is waited for here: the second request stands in the cycle right after the answer.
            end else begin
                @(posedge hclk);
            end
        end
    end
endmodule

// >>> verif/tb_oarg_gate.sv
module tb_oarg_gate import oarg_pkg::*; ();
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [KEY_W-1:0] K = {8{32'h5a3c0f91}};
    localparam logic [KEY_W-1:0] W = {8{32'h0c3e7b12}};
    localparam logic [KEY_W-1:0] P = {8{32'h91e4d2a7}};
    localparam logic [23:0] RT = {6'h0c, 6'h0b, 6'h3a, 6'h01};
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic bad2 = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [KEY_W-1:0] key_port_value = '0;
    logic hreadyout, hresp, uw_start, uw_stage, uw_done, irq;
    logic [2:0] dp_rights;
    logic [31:0] hrdata, st;
    logic [KEY_W-1:0] uw_key, uw_key_out;
    logic [ICV_W-1:0] uw_icv;
    oarg_sh_role_t sh_role;
    int errors = 0;
    int comparisons = 0;
    oarg_gate #(.BLOCK_DELAY_CYC(16'h0004)) dut (.hready(hreadyout), .*);
    oarg_unwrap_model #(.VAL_KEY(K), .WRAP_KEY(W)) partner (.*);
    initial begin
        forever #12.5 hclk = ~hclk;
    end
    task automatic stop_test;
        if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic role(input logic [5:0] e);
        chk({26'h0, dp_rights, sh_role}, {26'h0, e});
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        st = hrdata;
    endtask
    task automatic login(input logic [1:0] a, input logic [KEY_W-1:0] k);
        for (int i = 0; i < 8; i++) begin
            bus(ADDR_AUTH_BASE + 8'(4 * i), 1'b1, k[32*i+:32]);
        end
        bus(ADDR_CTRL, 1'b1, {26'h0, a, 4'h1});
        do bus(ADDR_STATUS, 1'b0, 32'h0); while (st[STAT_BUSY] !== 1'b0);
    endtask
    task automatic t_roles;
        for (int a = 0; a < 4; a++) begin
            login(2'(a), K);
            role(RT[6*a+:6]);
        end
    endtask
    task automatic t_fail;
        bus(ADDR_IRQ_MASK, 1'b1, 32'h2);
        login(2'h2, ~K);
        role(6'h00);
        chk(st & 32'h00ff0080, 32'h00010080);
        chk({31'h0, irq}, 32'h1);
        bus(ADDR_IRQ_STAT, 1'b1, 32'h7);
        @(posedge hclk);
        chk({31'h0, irq}, 32'h0);
        bad2 <= 1'b1;
        login(2'h3, K);
        role(6'h00);
        bad2 <= 1'b0;
    endtask
    task automatic t_dual;
        login(2'h1, K);
        bus(ADDR_ACCT_BASE + 8'h08, 1'b1, 32'h0a01);
        key_port_value <= P;
        login(2'h2, K);
        role(6'h00);
        login(2'h2, K ^ P);
        role(6'h0b);
        bus(ADDR_CTRL, 1'b1, 32'h2);
        @(posedge hclk);
        role(6'h00);
    endtask
    task automatic t_limit;
        login(2'h1, K);
        bus(ADDR_THRESH, 1'b1, 32'h3ff);
        bus(ADDR_THRESH, 1'b0, 32'h0);
        chk(st, 32'h280);
        bus(8'h18, 1'b0, 32'h0);
        chk(st, 32'h0);
        bus(ADDR_THRESH, 1'b1, 32'h2);
        // A limit of two lets the next failure reach the lockout instead of finding it already set.
        bus(ADDR_ACCT_BASE + 8'h0c, 1'b1, 32'h0200);
        login(2'h3, ~K);
        chk(st & 32'h0300, 32'h0200);
        bus(ADDR_IRQ_STAT, 1'b0, 32'h0);
        chk(st, 32'h7);
        login(2'h3, K);
        role(6'h00);
        chk(st & 32'h0300, 32'h0300);
        login(2'h0, K);
        role(6'h01);
    endtask
    task automatic t_reset;
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        role(6'h00);
        bus(ADDR_THRESH, 1'b0, 32'h0);
        chk(st, 32'h280);
    endtask
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        role(6'h00);
        bus(ADDR_THRESH, 1'b0, 32'h0);
        chk(st, 32'h280);
        t_roles;
        t_fail;
        t_dual;
        t_limit;
        t_reset;
        stop_test;
    end
    // The whole sequence needs a few hundred cycles; this leaves ample margin.
    initial begin
        #400us;
        errors++;
        stop_test;
    end
endmodule
